// ===== src/hpsc_defs.vh
`ifndef HPSC_DEFS_VH
`define HPSC_DEFS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define HPSC_IDX_W           6
`define HPSC_IDX_CTRL0       6'h02
`define HPSC_IDX_CTRL1       6'h0a
`define HPSC_IDX_CTRL2       6'h12
`define HPSC_IDX_CTRL3       6'h1a
`define HPSC_IDX_IND0        6'h03
`define HPSC_IDX_IND1        6'h0b
`define HPSC_IDX_IND2        6'h13
`define HPSC_IDX_IND3        6'h1b
`define HPSC_IDX_CFG         6'h20
`define HPSC_IDX_STAT        6'h21

// ==========================================================================
// Decoded register kinds
// ==========================================================================
`define HPSC_K_NONE          3'h0
`define HPSC_K_CTRL          3'h1
`define HPSC_K_IND           3'h2
`define HPSC_K_CFG           3'h3
`define HPSC_K_STAT          3'h4

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define HPSC_CTRL_RESET      6'h2d
`define HPSC_BIT_PWR         5
`define HPSC_BIT_BUS         4
`define HPSC_BIT_WIDE        3
`define HPSC_BIT_WREQ        2
`define HPSC_BIT_CLK         1
`define HPSC_BIT_RST         0
`define HPSC_IND_RESET       4'h0
`define HPSC_IND_A_LSB       0
`define HPSC_IND_B_LSB       2
`define HPSC_CFG_RESET       2'h0
`define HPSC_CFG_AUTO        0
`define HPSC_CFG_PROT        1

// ==========================================================================
// Indicator modes
// ==========================================================================
`define HPSC_MODE_LOW        2'h0
`define HPSC_MODE_SLOW       2'h1
`define HPSC_MODE_FAST       2'h2
`define HPSC_MODE_HIGH       2'h3

// ==========================================================================
// Timing and bus answers
// ==========================================================================
`define HPSC_CLK_HZ          20000000
`define HPSC_TOGGLE_MS       250
`define HPSC_TOGGLE_CYCLES   (`HPSC_TOGGLE_MS * (`HPSC_CLK_HZ / 1000))
`define HPSC_RESP_OKAY       2'h0
`define HPSC_RESP_SLVERR     2'h2

`endif

// ===== src/hpsc_blink.v
// ==========================================================================
// Blink phase generator
// ==========================================================================
module hpsc_blink #(
  parameter integer CNT_W         = 25,
  parameter integer TOGGLE_CYCLES = 5000000
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire fast_bus,
  output reg  slow_q,
  output reg  fast_q
);
  localparam integer     LIM_SLOW = TOGGLE_CYCLES - 1;
  localparam integer     LIM_FAST = 2 * TOGGLE_CYCLES - 1;

  reg  [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] lim;

  // A doubled bus clock needs twice the count for the same wall-clock period.
  assign lim = fast_bus ? LIM_FAST[CNT_W-1:0] : LIM_SLOW[CNT_W-1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= {CNT_W{1'b0}};
      slow_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q  <= {CNT_W{1'b0}};
      fast_q <= ~fast_q;
      if (fast_q) begin
        slow_q <= ~slow_q;
      end
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // hpsc_blink

// ===== src/hpsc_seq.v
// ==========================================================================
// Per-slot attach and detach sequencer
// ==========================================================================
module hpsc_seq (
  input  wire aclk,
  input  wire aresetn,
  input  wire start,
  input  wire detach,
  input  wire bus_quiet,
  input  wire cards_ok,
  output reg  req_q,
  output reg  busy_q,
  output reg  done_detach_q,
  output reg  done_attach_q
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_DONE = 2'h2;

  reg [1:0] state_q;
  reg       dir_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= S_IDLE;
      dir_q         <= 1'b0;
      req_q         <= 1'b0;
      busy_q        <= 1'b0;
      done_detach_q <= 1'b0;
      done_attach_q <= 1'b0;
    end else begin
      done_detach_q <= 1'b0;
      done_attach_q <= 1'b0;
      if (start) begin
        // A new write restarts the wait in the newly requested direction.
        state_q <= S_WAIT;
        dir_q   <= detach;
        req_q   <= 1'b1;
        busy_q  <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE: begin
            req_q  <= 1'b0;
            busy_q <= 1'b0;
          end
          S_WAIT: begin
            if (bus_quiet && (dir_q || cards_ok)) begin
              state_q       <= S_DONE;
              done_detach_q <= dir_q;
              done_attach_q <= ~dir_q;
            end
          end
          S_DONE: begin
            state_q <= S_IDLE;
            req_q   <= 1'b0;
            busy_q  <= 1'b0;
          end
          default: begin
            state_q <= S_IDLE;
            req_q   <= 1'b0;
            busy_q  <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // hpsc_seq

// ===== src/hpsc_top.v
`include "hpsc_defs.vh"

module hpsc_top #(
  parameter integer NSLOT         = 4,
  parameter integer CNT_W         = 25,
  parameter integer TOGGLE_CYCLES = `HPSC_TOGGLE_CYCLES
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             fast_bus_enable_input,
  input  wire             bus_quiet_grant,
  input  wire             pci_frame_n,
  input  wire             pci_irdy_n,
  input  wire [NSLOT-1:0] mech_detect0_n,
  input  wire [NSLOT-1:0] mech_detect1_n,
  output reg              bus_quiet_request,
  output reg  [NSLOT-1:0] bus_switch_out,
  output reg  [NSLOT-1:0] slot_clock_switch_out,
  output reg  [NSLOT-1:0] wide_request_switch_out,
  output reg  [NSLOT-1:0] slot_wide_indication,
  output reg  [NSLOT-1:0] slot_reset_out,
  output reg  [NSLOT-1:0] slot_power_out,
  output reg  [NSLOT-1:0] indicator_a_out,
  output reg  [NSLOT-1:0] indicator_b_out
);
  localparam integer SW = 2 * NSLOT + 4;

  // ========================================================================
  // Decoding and indicator functions
  // ========================================================================
  function [2:0] reg_kind;
    input [`HPSC_IDX_W-1:0] idx;
    begin
      case (idx)
        `HPSC_IDX_CTRL0, `HPSC_IDX_CTRL1,
        `HPSC_IDX_CTRL2, `HPSC_IDX_CTRL3: reg_kind = `HPSC_K_CTRL;
        `HPSC_IDX_IND0, `HPSC_IDX_IND1,
        `HPSC_IDX_IND2, `HPSC_IDX_IND3: reg_kind = `HPSC_K_IND;
        `HPSC_IDX_CFG: reg_kind = `HPSC_K_CFG;
        `HPSC_IDX_STAT: reg_kind = `HPSC_K_STAT;
        default: reg_kind = `HPSC_K_NONE;
      endcase
    end
  endfunction

  function ind_level;
    input [1:0] mode;
    input       slow;
    input       fast;
    begin
      case (mode)
        `HPSC_MODE_LOW: ind_level = 1'b0;
        `HPSC_MODE_SLOW: ind_level = slow;
        `HPSC_MODE_FAST: ind_level = fast;
        default: ind_level = 1'b1;
      endcase
    end
  endfunction

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;
  wire          s_fast;
  wire          s_grant;
  wire          s_frame_n;
  wire          s_irdy_n;
  wire [NSLOT-1:0] s_det0_n;
  wire [NSLOT-1:0] s_det1_n;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= {SW{1'b1}};
      sync2_q <= {SW{1'b1}};
    end else begin
      sync1_q <= {fast_bus_enable_input, bus_quiet_grant, pci_frame_n, pci_irdy_n,
                  mech_detect0_n, mech_detect1_n};
      sync2_q <= sync1_q;
    end
  end

  assign s_fast    = sync2_q[SW-1];
  assign s_grant   = sync2_q[SW-2];
  assign s_frame_n = sync2_q[SW-3];
  assign s_irdy_n  = sync2_q[SW-4];
  assign s_det0_n  = sync2_q[2*NSLOT-1:NSLOT];
  assign s_det1_n  = sync2_q[NSLOT-1:0];

  // ========================================================================
  // AXI4-Lite write channel
  // ========================================================================
  reg                    aw_full_q;
  reg                    w_full_q;
  reg [`HPSC_IDX_W-1:0]  aw_idx_q;
  reg [7:0]              w_data_q;
  reg                    w_lane0_q;
  wire                   wr_do;
  wire [2:0]             wr_kind;
  wire [1:0]             wr_slot;
  wire                   wr_ok;

  assign wr_do   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_kind = reg_kind(aw_idx_q);
  assign wr_slot = aw_idx_q[4:3];
  assign wr_ok   = wr_do & w_lane0_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_idx_q      <= {`HPSC_IDX_W{1'b0}};
      w_data_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HPSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        aw_idx_q      <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        w_data_q     <= s_axi_wdata[7:0];
        w_lane0_q    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_kind == `HPSC_K_NONE) ? `HPSC_RESP_SLVERR : `HPSC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Register file and sequencers
  // ========================================================================
  reg  [6*NSLOT-1:0] ctrl_q;
  reg  [4*NSLOT-1:0] ind_q;
  reg  [1:0]         cfg_q;
  reg  [NSLOT-1:0]   bus_q;
  wire [NSLOT-1:0]   seq_start;
  wire [NSLOT-1:0]   seq_req;
  wire [NSLOT-1:0]   seq_busy;
  wire [NSLOT-1:0]   done_det;
  wire [NSLOT-1:0]   done_att;
  wire [NSLOT-1:0]   cards_in;
  wire               bus_quiet;
  wire               auto_mode;
  wire               protect;
  integer            i;

  assign auto_mode = cfg_q[`HPSC_CFG_AUTO];
  assign protect   = cfg_q[`HPSC_CFG_PROT];
  // The grant alone is not trusted; the bus must also look idle here.
  assign bus_quiet = s_grant & s_frame_n & s_irdy_n;
  assign cards_in  = ~s_det0_n & ~s_det1_n;

  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
      assign seq_start[g] = wr_ok && auto_mode && (wr_kind == `HPSC_K_CTRL) &&
                            (wr_slot == g);
      hpsc_seq u_seq (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .start         (seq_start[g]),
        .detach        (w_data_q[`HPSC_BIT_BUS]),
        .bus_quiet     (bus_quiet),
        .cards_ok      (~protect | cards_in[g]),
        .req_q         (seq_req[g]),
        .busy_q        (seq_busy[g]),
        .done_detach_q (done_det[g]),
        .done_attach_q (done_att[g])
      );
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= {NSLOT{`HPSC_CTRL_RESET}};
      ind_q  <= {NSLOT{`HPSC_IND_RESET}};
      cfg_q  <= `HPSC_CFG_RESET;
      bus_q  <= {NSLOT{1'b0}};
    end else begin
      if (wr_ok && (wr_kind == `HPSC_K_CFG)) begin
        cfg_q <= w_data_q[1:0];
      end
      for (i = 0; i < NSLOT; i = i + 1) begin
        if (wr_ok && (wr_slot == i) && (wr_kind == `HPSC_K_CTRL)) begin
          ctrl_q[6*i +: 6] <= w_data_q[5:0];
        end
        if (wr_ok && (wr_slot == i) && (wr_kind == `HPSC_K_IND)) begin
          ind_q[4*i +: 4] <= w_data_q[3:0];
        end
        // The sequencer result lands after any same-cycle software write.
        if (done_det[i]) begin
          ctrl_q[6*i + `HPSC_BIT_CLK]  <= 1'b1;
          ctrl_q[6*i + `HPSC_BIT_WREQ] <= 1'b0;
          ctrl_q[6*i + `HPSC_BIT_PWR]  <= 1'b0;
        end
        if (!auto_mode) begin
          bus_q[i] <= ctrl_q[6*i + `HPSC_BIT_BUS];
        end else if (done_det[i]) begin
          bus_q[i] <= 1'b1;
        end else if (done_att[i]) begin
          bus_q[i] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  // ========================================================================
  reg [7:0]  rd_byte;
  wire [2:0] rd_kind;
  wire [1:0] rd_slot;

  assign rd_kind = reg_kind(s_axi_araddr[7:2]);
  assign rd_slot = s_axi_araddr[6:5];

  always @* begin
    rd_byte = 8'h00;
    case (rd_kind)
      `HPSC_K_CTRL: rd_byte = {2'b00, ctrl_q[6*rd_slot +: 6]};
      `HPSC_K_IND:  rd_byte = {4'h0, ind_q[4*rd_slot +: 4]};
      `HPSC_K_CFG:  rd_byte = {6'h00, cfg_q};
      `HPSC_K_STAT: rd_byte = {bus_q, seq_busy};
      default:      rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `HPSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= (rd_kind == `HPSC_K_NONE) ? `HPSC_RESP_SLVERR : `HPSC_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================================
  // Blink timing and slot outputs
  // ========================================================================
  wire blink_slow;
  wire blink_fast;

  hpsc_blink #(
    .CNT_W         (CNT_W),
    .TOGGLE_CYCLES (TOGGLE_CYCLES)
  ) u_blink (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fast_bus (s_fast),
    .slow_q   (blink_slow),
    .fast_q   (blink_fast)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_quiet_request       <= 1'b0;
      bus_switch_out          <= {NSLOT{1'b0}};
      slot_clock_switch_out   <= {NSLOT{1'b0}};
      wide_request_switch_out <= {NSLOT{1'b1}};
      slot_wide_indication    <= {NSLOT{1'b1}};
      slot_reset_out          <= {NSLOT{1'b1}};
      slot_power_out          <= {NSLOT{1'b0}};
      indicator_a_out         <= {NSLOT{1'b0}};
      indicator_b_out         <= {NSLOT{1'b0}};
    end else begin
      bus_quiet_request <= |seq_req;
      bus_switch_out    <= bus_q;
      for (i = 0; i < NSLOT; i = i + 1) begin
        slot_clock_switch_out[i]   <= ctrl_q[6*i + `HPSC_BIT_CLK];
        wide_request_switch_out[i] <= ctrl_q[6*i + `HPSC_BIT_WREQ];
        slot_wide_indication[i]    <= ctrl_q[6*i + `HPSC_BIT_WIDE];
        slot_reset_out[i]          <= ctrl_q[6*i + `HPSC_BIT_RST];
        // Protection keeps power off unless a card is fully seated.
        slot_power_out[i] <= ctrl_q[6*i + `HPSC_BIT_PWR] &
                             (~protect | cards_in[i]);
        indicator_a_out[i] <= ind_level(ind_q[4*i + `HPSC_IND_A_LSB +: 2],
                                        blink_slow, blink_fast);
        indicator_b_out[i] <= ind_level(ind_q[4*i + `HPSC_IND_B_LSB +: 2],
                                        blink_slow, blink_fast);
      end
    end
  end
endmodule // hpsc_top

// ===== bench/hpsc_top_props.sv
// ==========================================================================
// Port checker
// ==========================================================================
module hpsc_top_props #(
  parameter integer NSLOT = 4
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             bus_quiet_request,
  input wire logic             bus_quiet_grant,
  input wire logic             pci_frame_n,
  input wire logic             pci_irdy_n,
  input wire logic [NSLOT-1:0] mech_detect0_n,
  input wire logic [NSLOT-1:0] mech_detect1_n,
  input wire logic [NSLOT-1:0] bus_switch_out,
  input wire logic [NSLOT-1:0] slot_clock_switch_out,
  input wire logic [NSLOT-1:0] wide_request_switch_out,
  input wire logic [NSLOT-1:0] slot_power_out,
  input wire logic [NSLOT-1:0] slot_reset_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Detects are included so that a protected attach that must wait is not flagged.
  sequence s_idle_held;
    bus_quiet_request && bus_quiet_grant && pci_frame_n && pci_irdy_n &&
      !(|mech_detect0_n) && !(|mech_detect1_n);
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !bus_quiet_request && bus_switch_out == '0 &&
    slot_reset_out == {NSLOT{1'b1}}) else $error("outputs wrong during reset");
  a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_arready_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_quiet_drop: assert property (s_idle_held [*3] |-> ##[0:8] !bus_quiet_request)
    else $error("quiet request kept after idle grant");
  a_detach_state: assert property ($fell(bus_quiet_request) |-> ##[0:2]
    (bus_switch_out & (wide_request_switch_out | slot_power_out | ~slot_clock_switch_out)) == '0)
    else $error("detached slot switches wrong");
endmodule // hpsc_top_props

bind hpsc_top hpsc_top_props #(.NSLOT(NSLOT)) u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .bus_quiet_request, .bus_quiet_grant, .pci_frame_n,
  .pci_irdy_n, .mech_detect0_n, .mech_detect1_n, .bus_switch_out, .slot_clock_switch_out,
  .wide_request_switch_out, .slot_power_out, .slot_reset_out
);

// ===== bench/hpsc_idle_model.sv
// ==========================================================================
// Bus idle arbiter model
// ==========================================================================
module hpsc_idle_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic slow,
  input  wire logic bus_quiet_request,
  output wire logic bus_quiet_grant,
  output wire logic pci_frame_n,
  output wire logic pci_irdy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] act_q;
  logic [3:0] wait_q;
  wire  [3:0] limit = slow ? 4'h9 : 4'h2;
  wire        quiet = bus_quiet_request && (wait_q >= limit);

  always @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 4'h0;
      wait_q <= 4'h0;
    end else begin
      act_q <= act_q + 4'h1;
      wait_q <= !bus_quiet_request ? 4'h0 : (quiet ? wait_q : wait_q + 4'h1);
    end
  end

  // Traffic runs until the grant; the bus stays idle as long as the grant stands.
  assign bus_quiet_grant = quiet;
  assign pci_frame_n = quiet | act_q[1];
  assign pci_irdy_n = quiet | act_q[0];
endmodule // hpsc_idle_model

// ===== bench/tb.sv
`include "hpsc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TOG = 8;
  logic        aclk, aresetn, fast_bus_enable_input, pci_frame_n, pci_irdy_n, slow;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        bus_quiet_grant, bus_quiet_request;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, mech_detect0_n, mech_detect1_n, bus_switch_out;
  logic [3:0]  slot_clock_switch_out, wide_request_switch_out, slot_wide_indication;
  logic [3:0]  slot_reset_out, slot_power_out, indicator_a_out, indicator_b_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  tbl [4] = '{8'h3f, 8'h00, 8'h15, 8'h2a};
  int          err_total, n_compared;

  hpsc_top #(.TOGGLE_CYCLES(TOG)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_bus_enable_input, .bus_quiet_grant,
    .pci_frame_n, .pci_irdy_n, .mech_detect0_n, .mech_detect1_n, .bus_quiet_request,
    .bus_switch_out, .slot_clock_switch_out, .wide_request_switch_out, .slot_wide_indication,
    .slot_reset_out, .slot_power_out, .indicator_a_out, .indicator_b_out);
  hpsc_idle_model i_idle (.aclk, .aresetn, .slow, .bus_quiet_request, .bus_quiet_grant,
    .pci_frame_n, .pci_irdy_n);

  // ========================================================================
  // Checking and bus tasks
  // ========================================================================
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timed_out;
    err_total++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, where the registered readies are settled.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ah, wh, bh;
    logic [1:0] r;
    int n;
    n = 0;
    bh = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      if (++n > 50) timed_out();
    end
    chk(r, er);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er = 2'h0);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    rh = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
      if (++n > 50) timed_out();
    end
    chk(d, {24'h0, ed});
    chk(r, er);
  endtask
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      if (++n > 200) timed_out();
    end while (bus_quiet_request !== lvl);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic outs(input logic [5:0] e);
    chk({26'h0, slot_power_out[0], bus_switch_out[0], slot_wide_indication[0],
         wide_request_switch_out[0], slot_clock_switch_out[0], slot_reset_out[0]}, {26'h0, e});
  endtask
  task automatic blink(input int ea, input int eb);
    int ca, cb;
    logic pa, pb;
    ca = 0;
    cb = 0;
    settle(8);
    pa = indicator_a_out[0];
    pb = indicator_b_out[0];
    repeat (64) begin
      @(negedge aclk);
      ca += (indicator_a_out[0] !== pa);
      cb += (indicator_b_out[0] !== pb);
      pa = indicator_a_out[0];
      pb = indicator_b_out[0];
    end
    chk(ca, ea);
    chk(cb, eb);
  endtask

  // ========================================================================
  // Stimulus
  // ========================================================================
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    {aresetn, fast_bus_enable_input, slow, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {mech_detect0_n, mech_detect1_n, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    n_compared = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(3);
    outs(6'h2d);
    rd(`HPSC_IDX_CTRL0, 8'h2d);
    rd(6'h3f, 8'h00, `HPSC_RESP_SLVERR);
    wr(6'h3f, 8'h55, `HPSC_RESP_SLVERR);
    rd(`HPSC_IDX_IND2, 8'h00);
    wr(`HPSC_IDX_IND0, 8'hf1);
    wr(`HPSC_IDX_IND1, 8'hf2);
    wr(`HPSC_IDX_IND2, 8'hf4);
    wr(`HPSC_IDX_IND3, 8'hf8);
    rd(`HPSC_IDX_IND0, 8'h01);
    rd(`HPSC_IDX_IND1, 8'h02);
    rd(`HPSC_IDX_IND2, 8'h04);
    rd(`HPSC_IDX_IND3, 8'h08);
    foreach (tbl[i]) begin
      wr(`HPSC_IDX_CTRL0, tbl[i]);
      settle(3);
      outs(tbl[i][5:0]);
      rd(`HPSC_IDX_CTRL0, tbl[i]);
    end
    wr(`HPSC_IDX_CFG, 8'h02);
    wr(`HPSC_IDX_CTRL0, 8'h20);
    settle(4);
    chk(slot_power_out[0], 1'b1);
    @(posedge aclk);
    mech_detect0_n <= 4'hf;
    settle(5);
    chk(slot_power_out[0], 1'b0);
    @(posedge aclk);
    mech_detect0_n <= 4'h0;
    wr(`HPSC_IDX_CFG, 8'h01);
    wr(`HPSC_IDX_CTRL0, 8'h3f);
    wait_req(1'b1);
    wait_req(1'b0);
    settle(3);
    outs(6'h1b);
    rd(`HPSC_IDX_CTRL0, 8'h1b);
    rd(`HPSC_IDX_STAT, 8'h10);
    slow <= 1'b1;
    wr(`HPSC_IDX_CTRL0, 8'h0b);
    wait_req(1'b1);
    chk(bus_switch_out[0], 1'b1);
    wait_req(1'b0);
    settle(3);
    outs(6'h0b);
    wr(`HPSC_IDX_CFG, 8'h03);
    wr(`HPSC_IDX_CTRL0, 8'h1b);
    wait_req(1'b1);
    wait_req(1'b0);
    @(posedge aclk);
    mech_detect1_n <= 4'hf;
    wr(`HPSC_IDX_CTRL0, 8'h0b);
    wait_req(1'b1);
    settle(30);
    chk({bus_switch_out[0], bus_quiet_request}, 2'h3);
    @(posedge aclk);
    mech_detect1_n <= 4'h0;
    wait_req(1'b0);
    settle(3);
    chk(bus_switch_out[0], 1'b0);
    wr(`HPSC_IDX_IND0, 8'h03);
    settle(3);
    chk({indicator_b_out[0], indicator_a_out[0]}, 2'h1);
    wr(`HPSC_IDX_IND0, 8'h0c);
    settle(3);
    chk({indicator_b_out[0], indicator_a_out[0]}, 2'h2);
    wr(`HPSC_IDX_IND0, 8'h09);
    blink(64 / (2 * TOG), 64 / TOG);
    @(posedge aclk);
    fast_bus_enable_input <= 1'b1;
    blink(64 / (4 * TOG), 64 / (2 * TOG));
    print_verdict();
  end
endmodule // tb
